// ### src/cebc_pkg.sv
package cebc_pkg;

  // I/O addresses decoded from the buffered address bus
  localparam logic [9:0] NMI_GATE_ADDR = 10'h070;
  localparam logic [9:0] PORT_B_ADDR = 10'h061;
  localparam logic [9:0] MISC_CTRL_ADDR = 10'h060;
  localparam logic [9:0] BUS_TIMING_ADDR = 10'h06A;

  // Port B fields
  localparam int PB_PARITY_BIT = 7;
  localparam int PB_CHANNEL_BIT = 6;
  localparam int PB_T2OUT_BIT = 5;
  localparam int PB_REFDET_BIT = 4;
  localparam int PB_CHK_EN_BIT = 3;
  localparam int PB_PAR_EN_BIT = 2;
  localparam int PB_SPK_BIT = 1;
  localparam int PB_T2GATE_BIT = 0;
  localparam logic [3:0] PORT_B_RST = 4'h0;

  // NMI gate port
  localparam int NMI_DISABLE_BIT = 7;
  localparam logic NMI_EN_RST = 1'b0;

  // Misc control fields
  localparam int MISC_TMO_EN_BIT = 2;
  localparam int MISC_ALT_CLK_BIT = 4;
  localparam int MISC_TMO_FLAG_BIT = 7;
  localparam logic [7:0] MISC_CTRL_RST = 8'h00;

  // Bus timing fields: command delays in bus-state steps, waits in command states
  localparam int TIM_CD_LSB = 0;
  localparam int TIM_WS_LSB = 4;
  localparam int TIM_FIELD_W = 3;
  localparam logic [7:0] BUS_TIMING_RST = 8'h31;

  // Timing counts
  localparam int TIMEOUT_CLKS = 128;
  localparam logic [7:0] TIMEOUT_LAST = 8'(TIMEOUT_CLKS - 1);
  localparam logic [1:0] BYTE_GAP_STEPS = 2'h2;
  localparam logic [3:0] REFRESH_CMD_SYSCLKS = 4'h2;

  // Conversion codes
  localparam logic [1:0] CODE_WR_LOW = 2'h0;
  localparam logic [1:0] CODE_RD_LOW = 2'h1;
  localparam logic [1:0] CODE_WR_HIGH = 2'h2;
  localparam logic [1:0] CODE_RD_HIGH = 2'h3;
  localparam logic [1:0] CODE_DMA_FLOAT = 2'h0;

  typedef enum logic [1:0] {CP_IDLE, CP_SEND, CP_LOCAL, CP_BUS} cebc_cpu_state_t;

  typedef enum logic [2:0] {
    BS_IDLE, BS_SEND, BS_DELAY, BS_CMD, BS_GAP, BS_DONE
  } cebc_bus_state_t;

  typedef enum logic [3:0] {
    AR_IDLE, AR_REF_HOLD, AR_REF_WAIT, AR_REF_CMD, AR_REF_END,
    AR_DMA_HOLD, AR_DMA, AR_RELEASE
  } cebc_arb_state_t;

  // Pins from outside the clock domain
  typedef struct packed {
    logic alt_clk;
    logic hold_grant;
    logic recharge_req;
    logic dma_req;
    logic iochrdy;
    logic memcs16_n;
    logic iocs16_n;
    logic chk_n;
    logic par_n;
    logic io_wr_n;
    logic io_rd_n;
    logic t2_out;
  } cebc_pins_t;

  localparam cebc_pins_t PINS_RST = 12'h07E;

  // Captured processor cycle
  typedef struct packed {
    logic rd;
    logic io;
    logic high;
    logic word;
    logic a0;
  } cebc_cycle_t;

  localparam cebc_cycle_t CYCLE_RST = 5'h00;

endpackage

// ### src/cebc_bus_controller.sv
`timescale 1ns/1ps
module cebc_bus_controller
  import cebc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [1:0] cpu_status_n_in,
  input wire logic cpu_mio_in,
  input wire logic cpu_bhe_n_in,
  input wire logic cpu_a0_in,
  input wire logic local_bus_claim_in,
  input wire logic local_ready_n_in,
  output logic internal_addr_latch_pulse_out,
  output logic cpu_ready_n_out,
  output logic cpu_hold_req_out,
  input wire logic cpu_hold_grant_in,
  input wire logic alternate_bus_clock_in,
  input wire logic dram_recharge_request_in,
  input wire logic dma_hold_request_in,
  input wire logic dma_high_byte_in,
  input wire logic dma_read_in,
  output logic dma_hold_grant_out,
  output logic refresh_active_n_out,
  output logic [9:0] refresh_addr_out,
  output logic refresh_addr_oe_out,
  input wire logic iochrdy_in,
  input wire logic memcs16_n_in,
  input wire logic iocs16_n_in,
  output logic ale_out,
  output logic extended_addr_latch_pulse_out,
  output logic buffered_mem_read_cmd_n_out,
  output logic buffered_mem_write_cmd_n_out,
  output logic buffered_io_read_cmd_n_out,
  output logic buffered_io_write_cmd_n_out,
  output logic buffered_addr_bit0_out,
  output logic conversion_code_enable_n_out,
  output logic conversion_code_bit0_out,
  output logic conversion_code_bit1_out,
  input wire logic [9:0] io_addr_in,
  input wire logic io_wr_n_in,
  input wire logic io_rd_n_in,
  input wire logic [7:0] io_data_in,
  output logic [7:0] io_data_out,
  output logic io_data_oe_out,
  input wire logic io_channel_check_n_in,
  input wire logic parity_error_n_in,
  input wire logic timer2_out_in,
  output logic speaker_data_out,
  output logic timer2_gate_out,
  output logic nmi_out
);

  function automatic logic [1:0] cpu_code(input logic high, input logic rd);
    cpu_code = high ? (rd ? CODE_RD_HIGH : CODE_WR_HIGH) : (rd ? CODE_RD_LOW : CODE_WR_LOW);
  endfunction

  function automatic logic [11:0] settle(input logic [11:0] s2, input logic [11:0] s3,
                                         input logic [11:0] cur);
    settle = (s2 & ~(s2 ^ s3)) | (cur & (s2 ^ s3));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a level counts once the second and third stages agree

  cebc_pins_t raw;
  cebc_pins_t sync1_q, sync2_q, sync3_q, lvl_q, prev_q, rise;

  always_comb begin
    raw.alt_clk = alternate_bus_clock_in;
    raw.hold_grant = cpu_hold_grant_in;
    raw.recharge_req = dram_recharge_request_in;
    raw.dma_req = dma_hold_request_in;
    raw.iochrdy = iochrdy_in;
    raw.memcs16_n = memcs16_n_in;
    raw.iocs16_n = iocs16_n_in;
    raw.chk_n = io_channel_check_n_in;
    raw.par_n = parity_error_n_in;
    raw.io_wr_n = io_wr_n_in;
    raw.io_rd_n = io_rd_n_in;
    raw.t2_out = timer2_out_in;
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync1_q <= PINS_RST;
      sync2_q <= PINS_RST;
      sync3_q <= PINS_RST;
      lvl_q <= PINS_RST;
      prev_q <= PINS_RST;
    end else begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      lvl_q <= settle(sync2_q, sync3_q, lvl_q);
      prev_q <= lvl_q;
    end
  end

  assign rise = lvl_q & ~prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [3:0] port_b_q;
  logic [7:0] misc_q, timing_q;
  logic nmi_en_q, pck_q, chk_q, tmo_q, rfd_q, tmo_hit;
  logic wr_edge;

  assign wr_edge = rise.io_wr_n;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      port_b_q <= PORT_B_RST;
      misc_q <= MISC_CTRL_RST;
      timing_q <= BUS_TIMING_RST;
      nmi_en_q <= NMI_EN_RST;
    end else if (wr_edge) begin
      case (io_addr_in)
        NMI_GATE_ADDR: nmi_en_q <= ~io_data_in[NMI_DISABLE_BIT];
        PORT_B_ADDR: port_b_q <= io_data_in[3:0];
        MISC_CTRL_ADDR: misc_q <= io_data_in;
        BUS_TIMING_ADDR: timing_q <= io_data_in;
        default: nmi_en_q <= nmi_en_q;
      endcase
    end
  end

  // Error flags stay while their enable stays; the clear wins over a new event
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pck_q <= 1'b0;
      chk_q <= 1'b0;
      tmo_q <= 1'b0;
    end else begin
      pck_q <= (port_b_q[PB_PAR_EN_BIT] & ~lvl_q.par_n) |
               (pck_q & port_b_q[PB_PAR_EN_BIT]);
      chk_q <= (port_b_q[PB_CHK_EN_BIT] & ~lvl_q.chk_n) |
               (chk_q & port_b_q[PB_CHK_EN_BIT]);
      tmo_q <= (tmo_hit & misc_q[MISC_TMO_EN_BIT]) |
               (tmo_q & misc_q[MISC_TMO_EN_BIT]);
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      io_data_out <= 8'h00;
      io_data_oe_out <= 1'b0;
      nmi_out <= 1'b0;
    end else begin
      io_data_oe_out <= ~lvl_q.io_rd_n &
                        (io_addr_in == PORT_B_ADDR || io_addr_in == MISC_CTRL_ADDR ||
                         io_addr_in == BUS_TIMING_ADDR);
      case (io_addr_in)
        PORT_B_ADDR: io_data_out <= {pck_q, chk_q, lvl_q.t2_out, rfd_q, port_b_q};
        MISC_CTRL_ADDR: io_data_out <= {tmo_q, misc_q[6:0]};
        BUS_TIMING_ADDR: io_data_out <= timing_q;
        default: io_data_out <= 8'h00;
      endcase
      nmi_out <= nmi_en_q & (pck_q | chk_q | tmo_q);
    end
  end

  assign speaker_data_out = port_b_q[PB_SPK_BIT];
  assign timer2_gate_out = port_b_q[PB_T2GATE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Bus-state clock steps and system clock phase

  logic div_q, sysclk_q, bus_step, sys_rise;

  assign bus_step = misc_q[MISC_ALT_CLK_BIT] ? rise.alt_clk : div_q;
  assign sys_rise = bus_step & ~sysclk_q;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_q <= 1'b0;
      sysclk_q <= 1'b0;
    end else begin
      div_q <= ~div_q;
      if (bus_step) begin
        sysclk_q <= ~sysclk_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Processor-side state machine

  cebc_cpu_state_t cpu_state_q;
  cebc_cycle_t cyc_q;
  logic [7:0] tmo_cnt_q;
  logic bus_start_q, bus_done;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cpu_state_q <= CP_IDLE;
      cyc_q <= CYCLE_RST;
      tmo_cnt_q <= 8'h00;
      tmo_hit <= 1'b0;
    end else begin
      tmo_hit <= 1'b0;
      case (cpu_state_q)
        CP_IDLE: begin
          if (cpu_status_n_in != 2'h3 && !cpu_hold_req_out) begin
            cyc_q.rd <= ~cpu_status_n_in[1];
            cyc_q.io <= ~cpu_mio_in;
            cyc_q.high <= ~cpu_bhe_n_in & cpu_a0_in;
            cyc_q.word <= ~cpu_bhe_n_in & ~cpu_a0_in;
            cyc_q.a0 <= cpu_a0_in;
            cpu_state_q <= CP_SEND;
          end
        end
        CP_SEND: begin
          tmo_cnt_q <= 8'h00;
          cpu_state_q <= local_bus_claim_in ? CP_LOCAL : CP_BUS;
        end
        CP_LOCAL: begin
          if (!local_ready_n_in) begin
            cpu_state_q <= CP_IDLE;
          end else if (tmo_cnt_q == TIMEOUT_LAST) begin
            tmo_hit <= 1'b1;
            cpu_state_q <= CP_IDLE;
          end else begin
            tmo_cnt_q <= tmo_cnt_q + 8'h01;
          end
        end
        CP_BUS: begin
          if (bus_done) begin
            cpu_state_q <= CP_IDLE;
          end
        end
        default: cpu_state_q <= CP_IDLE;
      endcase
    end
  end

  assign internal_addr_latch_pulse_out = (cpu_state_q == CP_SEND);
  assign cpu_ready_n_out = ~((cpu_state_q == CP_LOCAL && !local_ready_n_in) ||
                             (cpu_state_q == CP_BUS && bus_done) || tmo_hit);

  ////////////////////////////////////////////////////////////////////////////
  // Expansion-bus state machine

  cebc_bus_state_t bus_state_q;
  logic [3:0] step_cnt_q;
  logic [TIM_FIELD_W-1:0] cd_cnt_q;
  logic is16_q, second_q;
  logic [TIM_FIELD_W-1:0] cd_set, ws_set;
  logic [3:0] cmd_last;
  logic cmd_on;

  assign cd_set = timing_q[TIM_CD_LSB +: TIM_FIELD_W];
  assign ws_set = timing_q[TIM_WS_LSB +: TIM_FIELD_W];
  assign cmd_last = {ws_set, 1'b1};
  assign cmd_on = (bus_state_q == BS_CMD);
  assign bus_done = (bus_state_q == BS_DONE);

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bus_start_q <= 1'b0;
    end else begin
      bus_start_q <= (cpu_state_q == CP_SEND && !local_bus_claim_in) |
                     (bus_start_q & (bus_state_q != BS_SEND));
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bus_state_q <= BS_IDLE;
      step_cnt_q <= 4'h0;
      cd_cnt_q <= '0;
      is16_q <= 1'b0;
      second_q <= 1'b0;
    end else begin
      case (bus_state_q)
        BS_IDLE: begin
          second_q <= 1'b0;
          if (bus_step && bus_start_q) begin
            bus_state_q <= BS_SEND;
          end
        end
        BS_SEND: begin
          if (bus_step) begin
            is16_q <= ~cyc_q.io & ~lvl_q.memcs16_n;
            cd_cnt_q <= cd_set;
            step_cnt_q <= 4'h0;
            bus_state_q <= (cd_set == '0) ? BS_CMD : BS_DELAY;
          end
        end
        BS_DELAY: begin
          if (bus_step) begin
            cd_cnt_q <= cd_cnt_q - 1'b1;
            if (cd_cnt_q == 1) begin
              bus_state_q <= BS_CMD;
            end
          end
        end
        BS_CMD: begin
          if (bus_step) begin
            if (cyc_q.io && step_cnt_q == 4'h1 && !second_q) begin
              is16_q <= ~lvl_q.iocs16_n;
            end
            if (step_cnt_q != cmd_last) begin
              step_cnt_q <= step_cnt_q + 4'h1;
            end else if (lvl_q.iochrdy) begin
              step_cnt_q <= 4'h0;
              if (cyc_q.word && !is16_q && !second_q) begin
                second_q <= 1'b1;
                bus_state_q <= BS_GAP;
              end else begin
                bus_state_q <= BS_DONE;
              end
            end
          end
        end
        BS_GAP: begin
          if (bus_step) begin
            step_cnt_q <= step_cnt_q + 4'h1;
            if (step_cnt_q[1:0] == BYTE_GAP_STEPS - 2'h1) begin
              step_cnt_q <= 4'h0;
              bus_state_q <= BS_CMD;
            end
          end
        end
        BS_DONE: bus_state_q <= BS_IDLE;
        default: bus_state_q <= BS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbiter for refresh and DMA

  cebc_arb_state_t arb_state_q;
  logic ref_pend_q, hold_q, ref_act_q, ref_rd_q, dma_grant_q;
  logic [3:0] ref_cnt_q;
  logic [9:0] row_q;
  logic ref_take;

  assign ref_take = (arb_state_q == AR_IDLE) && ref_pend_q && sys_rise;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ref_pend_q <= 1'b0;
    end else begin
      ref_pend_q <= rise.recharge_req | (ref_pend_q & ~ref_take);
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      arb_state_q <= AR_IDLE;
      hold_q <= 1'b0;
      ref_act_q <= 1'b0;
      ref_rd_q <= 1'b0;
      dma_grant_q <= 1'b0;
      ref_cnt_q <= 4'h0;
      row_q <= 10'h000;
      rfd_q <= 1'b0;
    end else begin
      case (arb_state_q)
        AR_IDLE: begin
          if (ref_take) begin
            hold_q <= 1'b1;
            arb_state_q <= AR_REF_HOLD;
          end else if (lvl_q.dma_req && !ref_pend_q && !rise.recharge_req &&
                       bus_state_q == BS_IDLE) begin
            hold_q <= 1'b1;
            arb_state_q <= AR_DMA_HOLD;
          end
        end
        AR_REF_HOLD: begin
          if (lvl_q.hold_grant) begin
            ref_act_q <= 1'b1;
            ref_cnt_q <= 4'h0;
            arb_state_q <= AR_REF_WAIT;
          end
        end
        AR_REF_WAIT: begin
          if (sys_rise) begin
            ref_cnt_q <= ref_cnt_q + 4'h1;
            if (ref_cnt_q == 4'h1) begin
              ref_rd_q <= 1'b1;
              ref_cnt_q <= 4'h0;
              arb_state_q <= AR_REF_CMD;
            end
          end
        end
        AR_REF_CMD: begin
          if (sys_rise) begin
            ref_cnt_q <= ref_cnt_q + 4'h1;
            if (ref_cnt_q == REFRESH_CMD_SYSCLKS - 4'h1) begin
              ref_rd_q <= 1'b0;
              row_q <= row_q + 10'h001;
              rfd_q <= ~rfd_q;
              arb_state_q <= AR_REF_END;
            end
          end
        end
        AR_REF_END: begin
          if (sys_rise) begin
            ref_act_q <= 1'b0;
            hold_q <= 1'b0;
            arb_state_q <= AR_RELEASE;
          end
        end
        AR_DMA_HOLD: begin
          if (lvl_q.hold_grant) begin
            dma_grant_q <= 1'b1;
            arb_state_q <= AR_DMA;
          end
        end
        AR_DMA: begin
          if (!lvl_q.dma_req) begin
            dma_grant_q <= 1'b0;
            hold_q <= 1'b0;
            arb_state_q <= AR_RELEASE;
          end
        end
        AR_RELEASE: begin
          if (!lvl_q.hold_grant) begin
            arb_state_q <= AR_IDLE;
          end
        end
        default: arb_state_q <= AR_IDLE;
      endcase
    end
  end

  assign cpu_hold_req_out = hold_q;
  assign dma_hold_grant_out = dma_grant_q;
  assign refresh_active_n_out = ~ref_act_q;
  assign refresh_addr_out = row_q;
  assign refresh_addr_oe_out = ref_act_q;

  ////////////////////////////////////////////////////////////////////////////
  // Commands, latch enables and conversion codes

  logic [1:0] code;

  assign ale_out = (bus_state_q == BS_SEND) | dma_grant_q;
  assign extended_addr_latch_pulse_out = (bus_state_q == BS_SEND) | dma_grant_q;
  assign buffered_mem_read_cmd_n_out = ~((cmd_on & ~cyc_q.io & cyc_q.rd) | ref_rd_q);
  assign buffered_mem_write_cmd_n_out = ~(cmd_on & ~cyc_q.io & ~cyc_q.rd);
  assign buffered_io_read_cmd_n_out = ~(cmd_on & cyc_q.io & cyc_q.rd);
  assign buffered_io_write_cmd_n_out = ~(cmd_on & cyc_q.io & ~cyc_q.rd);
  assign buffered_addr_bit0_out = second_q | cyc_q.a0;

  always_comb begin
    code = CODE_DMA_FLOAT;
    conversion_code_enable_n_out = 1'b1;
    if (dma_grant_q) begin
      code = dma_high_byte_in ? {1'b1, dma_read_in} : CODE_DMA_FLOAT;
      conversion_code_enable_n_out = 1'b0;
    end else if (ref_act_q) begin
      conversion_code_enable_n_out = 1'b1;
    end else if (bus_state_q != BS_IDLE) begin
      code = cpu_code(cyc_q.high | second_q, cyc_q.rd);
      conversion_code_enable_n_out = cyc_q.rd ? ~cmd_on : 1'b0;
    end
  end

  assign conversion_code_bit0_out = code[0];
  assign conversion_code_bit1_out = code[1];

endmodule

// ### verification/cebc_far_side.sv
`timescale 1ns/1ps
module cebc_far_side (
  input wire logic mclk_in,
  input wire logic hold_req_in,
  input wire logic cmd_n_in,
  input wire logic [3:0] slow_in,
  output logic hold_grant_out,
  output logic chrdy_out
);
  logic [3:0] lag_q = 4'h0;
  logic [3:0] cnt_q = 4'h0;
  always @(posedge mclk_in) begin
    lag_q <= {lag_q[2:0], hold_req_in};
    cnt_q <= cmd_n_in ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hF};
  end
  // Processor grants and releases hold some clocks late
  assign hold_grant_out = lag_q[3];
  // Card holds channel ready low for slow_in clocks; pulled up when idle
  assign chrdy_out = cmd_n_in || cnt_q >= slow_in;
endmodule

// ### verification/cebc_bus_controller_properties.sv
`timescale 1ns/1ps
module cebc_chk (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic local_bus_claim_in,
  input wire logic local_ready_n_in,
  input wire logic internal_addr_latch_pulse_out,
  input wire logic cpu_ready_n_out,
  input wire logic cpu_hold_req_out,
  input wire logic dma_hold_request_in,
  input wire logic dma_hold_grant_out,
  input wire logic refresh_active_n_out,
  input wire logic refresh_addr_oe_out,
  input wire logic ale_out,
  input wire logic extended_addr_latch_pulse_out,
  input wire logic buffered_mem_read_cmd_n_out,
  input wire logic conversion_code_enable_n_out
);
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);
  chk_latch_one_cycle: assert property (internal_addr_latch_pulse_out |=>
    !internal_addr_latch_pulse_out) else $error("latch pulse too long");
  chk_local_ready: assert property (internal_addr_latch_pulse_out && local_bus_claim_in
    ##1 !local_ready_n_in |-> !cpu_ready_n_out) else $error("local ready lost");
  chk_local_quiet: assert property (internal_addr_latch_pulse_out && local_bus_claim_in
    |=> !ale_out && conversion_code_enable_n_out) else $error("local cycle on bus");
  chk_timeout_bound: assert property (internal_addr_latch_pulse_out && local_bus_claim_in
    |-> ##[1:132] !cpu_ready_n_out) else $error("no time-out ready");
  chk_owner_single: assert property (!(dma_hold_grant_out && !refresh_active_n_out))
    else $error("two bus owners");
  chk_grant_hold: assert property (dma_hold_grant_out || !refresh_active_n_out |->
    cpu_hold_req_out) else $error("owner without hold");
  chk_row_drive: assert property (!refresh_active_n_out |-> refresh_addr_oe_out)
    else $error("row address not driven");
  chk_refresh_read: assert property ($fell(refresh_active_n_out) |->
    buffered_mem_read_cmd_n_out [*2] ##[1:10] !buffered_mem_read_cmd_n_out)
    else $error("refresh read timing");
  chk_read_first: assert property ($rose(buffered_mem_read_cmd_n_out) &&
    !refresh_active_n_out |=> !refresh_active_n_out) else $error("refresh end order");
  chk_dma_keep: assert property (dma_hold_grant_out && dma_hold_request_in |=>
    dma_hold_grant_out) else $error("grant dropped early");
  chk_dma_lines: assert property (dma_hold_grant_out |-> ale_out &&
    extended_addr_latch_pulse_out && !conversion_code_enable_n_out) else $error("dma lines");
endmodule
bind cebc_bus_controller cebc_chk u_chk (.*);

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
  import cebc_pkg::*;
  logic mclk_in = 0, nrst_in = 0, cpu_mio_in = 1, cpu_bhe_n_in = 1, cpu_a0_in = 0;
  logic local_bus_claim_in = 0, local_ready_n_in = 1, cpu_hold_grant_in, iochrdy_in;
  logic alternate_bus_clock_in = 0, dram_recharge_request_in = 0, dma_hold_request_in = 0;
  logic dma_high_byte_in = 0, dma_read_in = 0, memcs16_n_in = 1, iocs16_n_in = 1;
  logic io_wr_n_in = 1, io_rd_n_in = 1, io_channel_check_n_in = 1, parity_error_n_in = 1;
  logic timer2_out_in = 1, internal_addr_latch_pulse_out, cpu_ready_n_out, cpu_hold_req_out;
  logic dma_hold_grant_out, refresh_active_n_out, refresh_addr_oe_out, ale_out, nmi_out;
  logic extended_addr_latch_pulse_out, buffered_mem_read_cmd_n_out, io_data_oe_out;
  logic buffered_mem_write_cmd_n_out, buffered_io_read_cmd_n_out, buffered_io_write_cmd_n_out;
  logic buffered_addr_bit0_out, conversion_code_enable_n_out, conversion_code_bit0_out;
  logic conversion_code_bit1_out, speaker_data_out, timer2_gate_out, cmd_n;
  logic oe_d = 0, ale_d = 0, cmd_d = 1;
  logic [1:0] a0s = 2'h0;
  logic [1:0] cpu_status_n_in = 2'h3, code;
  logic [3:0] slow = 4'h3;
  logic [9:0] io_addr_in = 10'h000, refresh_addr_out;
  logic [7:0] io_data_in = 8'h00, io_data_out, v;
  logic [7:0] exp_q[$];
  int n_errors = 0, checked = 0, n = 0, cmds = 0, ales = 0, seed = 32'h5f742751;
  initial forever #12.5 mclk_in = ~mclk_in;
  cebc_bus_controller u_dut (.*);
  cebc_far_side u_far (.mclk_in(mclk_in), .hold_req_in(cpu_hold_req_out), .cmd_n_in(cmd_n),
    .slow_in(slow), .hold_grant_out(cpu_hold_grant_in), .chrdy_out(iochrdy_in));
  assign cmd_n = buffered_io_read_cmd_n_out & buffered_io_write_cmd_n_out &
    buffered_mem_read_cmd_n_out & buffered_mem_write_cmd_n_out;
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic g, input logic e);
    chk_reg({7'h00, g}, {7'h00, e});
  endtask
  task automatic tick(input int k = 1);
    repeat (k) @(posedge mclk_in);
    #2;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    io_addr_in = a;
    io_data_in = d;
    io_wr_n_in = 0;
    tick(2);
    io_wr_n_in = 1;
    tick(6);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e, input logic ok = 1);
    io_addr_in = a;
    if (ok) exp_q.push_back(e);
    io_rd_n_in = 0;
    tick(8);
    io_rd_n_in = 1;
    tick(6);
  endtask
  task automatic cpu(input logic [1:0] st, input logic cl);
    cmds = 0;
    ales = 0;
    n = 0;
    cpu_status_n_in = st;
    local_bus_claim_in = cl;
    tick;
    cpu_status_n_in = 2'h3;
    while (cpu_ready_n_out !== 1'b0 && n < 400) begin
      tick;
      n++;
    end
    tick;
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Read data is matched to the oldest expectation as it appears
  always @(negedge mclk_in) begin
    if (io_data_oe_out === 1'b1 && oe_d !== 1'b1) begin
      if (exp_q.size() == 0) chk_pin(io_data_oe_out, 1'b0);
      else chk_reg(io_data_out, exp_q.pop_front());
    end
    if (cmd_n === 1'b0 && cmd_d === 1'b1) begin
      cmds++;
      code = {conversion_code_bit1_out, conversion_code_bit0_out};
      a0s = {a0s[0], buffered_addr_bit0_out};
    end
    if (ale_out === 1'b1 && ale_d === 1'b0) ales++;
    oe_d = io_data_oe_out;
    cmd_d = cmd_n;
    ale_d = ale_out;
  end
  initial begin
    #2_000_000;
    n_errors++;
    finish_test;
  end
  initial begin
    tick(8);
    nrst_in = 1;
    tick(6);
    rd(PORT_B_ADDR, 8'h20);
    rd(BUS_TIMING_ADDR, BUS_TIMING_RST);
    rd(MISC_CTRL_ADDR, MISC_CTRL_RST);
    rd(10'h065, 8'h00, 0);
    v = 8'($random(seed));
    wr(PORT_B_ADDR, v | 8'hF0);
    rd(PORT_B_ADDR, {4'h2, v[3:0]});
    chk_pin(speaker_data_out, v[1]);
    chk_pin(timer2_gate_out, v[0]);
    $display("test registers done");
    wr(NMI_GATE_ADDR, 8'h00);
    wr(PORT_B_ADDR, 8'h04);
    parity_error_n_in = 0;
    tick(6);
    parity_error_n_in = 1;
    tick(2);
    chk_pin(nmi_out, 1'b1);
    rd(PORT_B_ADDR, 8'hA4);
    wr(NMI_GATE_ADDR, 8'h80);
    chk_pin(nmi_out, 1'b0);
    wr(PORT_B_ADDR, 8'h00);
    wr(NMI_GATE_ADDR, 8'h00);
    $display("test nmi done");
    wr(MISC_CTRL_ADDR, 8'h04);
    cpu(2'h2, 1);
    chk_pin(n > 125 && n < 133, 1'b1);
    tick(2);
    chk_pin(nmi_out, 1'b1);
    rd(MISC_CTRL_ADDR, 8'h84);
    wr(MISC_CTRL_ADDR, 8'h00);
    local_ready_n_in = 0;
    cpu(2'h1, 1);
    chk_pin(n < 4, 1'b1);
    chk_reg(8'(ales), 8'h00);
    $display("test local done");
    cpu_mio_in = 0;
    io_addr_in = 10'h300;
    for (int i = 0; i < 4; i++) begin
      cpu_bhe_n_in = !i[1];
      cpu_a0_in = i[1];
      slow = 4'($random(seed));
      cpu(i[0] ? 2'h1 : 2'h2, 0);
      chk_reg({6'h00, code}, {6'h00, i[1], i[0]});
      chk_reg(8'(cmds), 8'h01);
      chk_pin(n > slow, 1'b1);
    end
    cpu_bhe_n_in = 0;
    cpu_a0_in = 0;
    cpu(2'h1, 0);
    chk_reg(8'(cmds), 8'h02);
    chk_reg(8'(ales), 8'h01);
    chk_reg({6'h00, a0s}, 8'h01);
    cpu_mio_in = 1;
    cpu(2'h2, 0);
    chk_reg(8'(cmds), 8'h02);
    cpu_mio_in = 0;
    iocs16_n_in = 0;
    cpu(2'h1, 0);
    chk_reg(8'(cmds), 8'h01);
    $display("test bus done");
    dma_read_in = 1;
    dma_high_byte_in = 1;
    dram_recharge_request_in = 1;
    dma_hold_request_in = 1;
    tick(2);
    dram_recharge_request_in = 0;
    n = 0;
    while (refresh_active_n_out !== 1'b0 && dma_hold_grant_out !== 1'b1 && n < 100) begin
      tick;
      n++;
    end
    chk_pin(refresh_active_n_out, 1'b0);
    cmds = 0;
    n = 0;
    while (dma_hold_grant_out !== 1'b1 && n < 200) begin
      tick;
      n++;
    end
    chk_reg(8'(cmds), 8'h01);
    chk_reg({6'h00, conversion_code_bit1_out, conversion_code_bit0_out}, 8'h03);
    dma_read_in = 0;
    tick(4);
    chk_reg({6'h00, conversion_code_bit1_out, conversion_code_bit0_out}, 8'h02);
    dma_high_byte_in = 0;
    tick(20);
    chk_reg({6'h00, conversion_code_bit1_out, conversion_code_bit0_out}, 8'h00);
    chk_pin(dma_hold_grant_out, 1'b1);
    dma_hold_request_in = 0;
    tick(20);
    chk_pin(dma_hold_grant_out | cpu_hold_req_out, 1'b0);
    rd(PORT_B_ADDR, 8'h30);
    chk_reg(refresh_addr_out[7:0], 8'h01);
    chk_reg(8'(exp_q.size()), 8'h00);
    $display("test arbitration done");
    finish_test;
  end
endmodule
